// file: rtl/sctr_defines.vh
// constants for the system control and thermal register bank
`ifndef SCTR_DEFINES_VH
`define SCTR_DEFINES_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SCTR_OFF_SYSCTL2     8'h37
`define SCTR_OFF_DERATE      8'h61
`define SCTR_OFF_COLD        8'h62
`define SCTR_OFF_COOL        8'h63
`define SCTR_OFF_WARM        8'h64
`define SCTR_OFF_HOT         8'h65
`define SCTR_OFF_PGMODE      8'h36
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SCTR_RST_SYSCTL2     8'h40
`define SCTR_RST_DERATE      8'h34
`define SCTR_RST_COLD        8'h7C
`define SCTR_RST_COOL        8'h6D
`define SCTR_RST_WARM        8'h38
`define SCTR_RST_HOT         8'h27
`define SCTR_RST_PGMODE      8'h00
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SCTR_RAIL_HI         7
`define SCTR_RAIL_LO         5
`define SCTR_GPO_BIT         4
`define SCTR_WD_BIT          1
`define SCTR_CHGDIS_BIT      0
`define SCTR_VDER_HI         6
`define SCTR_VDER_LO         4
`define SCTR_IDER_HI         2
`define SCTR_IDER_LO         0
`define SCTR_PGM_HI          3
`define SCTR_PGM_LO          2
// writable masks: sysctl2 bits 3-2 reserved read as zero
`define SCTR_MASK_SYSCTL2    8'hF3
`define SCTR_MASK_PGMODE     8'hFF
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SCTR_WD_TIME_S       32'h0000000E
`define SCTR_CLK_HZ          32'h07735940
`define SCTR_WD_CYCLES       (`SCTR_WD_TIME_S * `SCTR_CLK_HZ)
// hardware reset pulse length in cycles
`define SCTR_HWRST_CYCLES    5'h10
`endif

// file: rtl/sctr_regbank.v
// system control and thermal threshold register bank
`timescale 1ns/100ps
`default_nettype none
`include "sctr_defines.vh"
module sctr_regbank #(
  parameter [31:0] WD_CYCLES    = `SCTR_WD_CYCLES,
  parameter [4:0]  HWRST_CYCLES = `SCTR_HWRST_CYCLES
) (
  // clock and reset
  input  wire       mclk,
  input  wire       rstn,
  // register access from the serial bus slave
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  input  wire       bus_txn_done,
  // pins and analog side
  input  wire       input_supply_good,
  input  wire       charge_en_pin_n,
  input  wire       input_power_good,
  input  wire       button_level_n,
  input  wire [7:0] thermistor_sense,
  output wire       power_good_pin_n_o,
  output wire       power_good_pin_n_oe,
  // control outputs
  output reg  [2:0] sys_rail_target_sel_q,
  output reg        charge_allowed_q,
  output reg  [2:0] zone_q,
  output reg  [2:0] warm_voltage_derate_q,
  output reg  [2:0] thermal_current_derate_q,
  output reg        hw_reset_q
);
  // ---------------------------------------------------------------
  // zone codes
  // ---------------------------------------------------------------
  localparam [2:0] ZN_NORMAL = 3'h0;
  localparam [2:0] ZN_COLD   = 3'h1;
  localparam [2:0] ZN_COOL   = 3'h2;
  localparam [2:0] ZN_WARM   = 3'h3;
  localparam [2:0] ZN_HOT    = 3'h4;
  // watchdog states
  localparam [1:0] WD_IDLE   = 2'h0;
  localparam [1:0] WD_RUN    = 2'h1;
  localparam [1:0] WD_DONE   = 2'h2;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [7:0]  sysctl2_q;
  reg  [7:0]  derate_q;
  reg  [7:0]  cold_q;
  reg  [7:0]  cool_q;
  reg  [7:0]  warm_q;
  reg  [7:0]  hot_q;
  reg  [7:0]  pgmode_q;
  reg  [1:0]  wd_state_q;
  reg  [31:0] wd_cnt_q;
  reg  [4:0]  hwrst_cnt_q;
  reg         supply_prev_q;
  wire        supply_s;
  wire        ce_s;
  wire        good_s;
  wire        btn_s;
  wire        wd_fire;

  // pin inputs from outside the clock domain
  sctr_sync #(.RST_VAL(1'b0)) u_sync_supply (.mclk(mclk), .rstn(rstn), .din(input_supply_good), .dout_q(supply_s));
  sctr_sync #(.RST_VAL(1'b1)) u_sync_ce     (.mclk(mclk), .rstn(rstn), .din(charge_en_pin_n),   .dout_q(ce_s));
  sctr_sync #(.RST_VAL(1'b0)) u_sync_good   (.mclk(mclk), .rstn(rstn), .din(input_power_good),  .dout_q(good_s));
  sctr_sync #(.RST_VAL(1'b1)) u_sync_btn    (.mclk(mclk), .rstn(rstn), .din(button_level_n),    .dout_q(btn_s));

  function [7:0] sel_rd;
    input [7:0] a;
    input [7:0] r0, r1, r2, r3, r4, r5, r6;
    begin
      case (a)
        `SCTR_OFF_SYSCTL2: sel_rd = r0 & `SCTR_MASK_SYSCTL2;
        `SCTR_OFF_DERATE:  sel_rd = r1;
        `SCTR_OFF_COLD:    sel_rd = r2;
        `SCTR_OFF_COOL:    sel_rd = r3;
        `SCTR_OFF_WARM:    sel_rd = r4;
        `SCTR_OFF_HOT:     sel_rd = r5;
        `SCTR_OFF_PGMODE:  sel_rd = r6;
        default:           sel_rd = 8'h00;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // register writes; hardware reset returns every default
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sysctl2_q <= `SCTR_RST_SYSCTL2;
      derate_q  <= `SCTR_RST_DERATE;
      cold_q    <= `SCTR_RST_COLD;
      cool_q    <= `SCTR_RST_COOL;
      warm_q    <= `SCTR_RST_WARM;
      hot_q     <= `SCTR_RST_HOT;
      pgmode_q  <= `SCTR_RST_PGMODE;
    end else if (hw_reset_q) begin
      sysctl2_q <= `SCTR_RST_SYSCTL2;
      derate_q  <= `SCTR_RST_DERATE;
      cold_q    <= `SCTR_RST_COLD;
      cool_q    <= `SCTR_RST_COOL;
      warm_q    <= `SCTR_RST_WARM;
      hot_q     <= `SCTR_RST_HOT;
      pgmode_q  <= `SCTR_RST_PGMODE;
    end else if (reg_wr) begin
      case (reg_addr)
        `SCTR_OFF_SYSCTL2: sysctl2_q <= reg_wdata & `SCTR_MASK_SYSCTL2;
        `SCTR_OFF_DERATE:  derate_q  <= reg_wdata;
        `SCTR_OFF_COLD:    cold_q    <= reg_wdata;
        `SCTR_OFF_COOL:    cool_q    <= reg_wdata;
        `SCTR_OFF_WARM:    warm_q    <= reg_wdata;
        `SCTR_OFF_HOT:     hot_q     <= reg_wdata;
        `SCTR_OFF_PGMODE:  pgmode_q  <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // read data registered on the read strobe; unmapped reads zero
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= sel_rd(reg_addr, sysctl2_q, derate_q, cold_q, cool_q, warm_q, hot_q, pgmode_q);
    end
  end

  // ---------------------------------------------------------------
  // post-attach watchdog
  // ---------------------------------------------------------------
  assign wd_fire = (wd_state_q == WD_RUN) && (wd_cnt_q >= WD_CYCLES - 32'h1);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wd_state_q <= WD_IDLE;
      wd_cnt_q   <= 32'h0;
      supply_prev_q <= 1'b0;
    end else begin
      supply_prev_q <= supply_s;
      case (wd_state_q)
        WD_IDLE: begin
          wd_cnt_q <= 32'h0;
          // armed afresh on each new input attach
          if (supply_s && !supply_prev_q && sysctl2_q[`SCTR_WD_BIT]) begin
            wd_state_q <= WD_RUN;
          end
        end
        WD_RUN: begin
          wd_cnt_q <= wd_cnt_q + 32'h1;
          if (!supply_s || !sysctl2_q[`SCTR_WD_BIT] || hw_reset_q) begin
            wd_state_q <= WD_IDLE;
          end else if (bus_txn_done) begin
            wd_state_q <= WD_DONE;
          end else if (wd_fire) begin
            wd_state_q <= WD_DONE;
          end
        end
        WD_DONE: begin
          wd_cnt_q <= 32'h0;
          if (!supply_s) begin
            wd_state_q <= WD_IDLE;
          end
        end
        default: wd_state_q <= WD_IDLE;
      endcase
    end
  end

  // reset pulse; a transaction in the final cycle still wins
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hwrst_cnt_q <= 5'h0;
      hw_reset_q  <= 1'b0;
    end else if (wd_fire && !bus_txn_done && supply_s && sysctl2_q[`SCTR_WD_BIT]) begin
      hwrst_cnt_q <= HWRST_CYCLES - 5'h1;
      hw_reset_q  <= 1'b1;
    end else if (hwrst_cnt_q != 5'h0) begin
      hwrst_cnt_q <= hwrst_cnt_q - 5'h1;
    end else begin
      hw_reset_q  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // power good pin: 1x general output, 00 input good, 01 button
  // ---------------------------------------------------------------
  reg pin_pull_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_pull_q <= 1'b0;
    end else if (pgmode_q[`SCTR_PGM_HI]) begin
      pin_pull_q <= !sysctl2_q[`SCTR_GPO_BIT];
    end else if (pgmode_q[`SCTR_PGM_LO]) begin
      pin_pull_q <= !btn_s;
    end else begin
      pin_pull_q <= good_s;
    end
  end
  // open drain: only ever drives low
  assign power_good_pin_n_o  = 1'b0;
  assign power_good_pin_n_oe = pin_pull_q;

  // ---------------------------------------------------------------
  // control outputs and thermal zone
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sys_rail_target_sel_q    <= 3'h2;
      charge_allowed_q         <= 1'b0;
      zone_q                   <= ZN_NORMAL;
      warm_voltage_derate_q    <= 3'h0;
      thermal_current_derate_q <= 3'h0;
    end else begin
      sys_rail_target_sel_q <= sysctl2_q[`SCTR_RAIL_HI:`SCTR_RAIL_LO];
      charge_allowed_q      <= !sysctl2_q[`SCTR_CHGDIS_BIT] && !ce_s && !hw_reset_q;
      // higher sense voltage means colder with an ntc divider
      if (thermistor_sense >= cold_q) begin
        zone_q <= ZN_COLD;
      end else if (thermistor_sense >= cool_q) begin
        zone_q <= ZN_COOL;
      end else if (thermistor_sense <= hot_q) begin
        zone_q <= ZN_HOT;
      end else if (thermistor_sense <= warm_q) begin
        zone_q <= ZN_WARM;
      end else begin
        zone_q <= ZN_NORMAL;
      end
      if (zone_q == ZN_WARM) begin
        warm_voltage_derate_q    <= derate_q[`SCTR_VDER_HI:`SCTR_VDER_LO];
        thermal_current_derate_q <= derate_q[`SCTR_IDER_HI:`SCTR_IDER_LO];
      end else begin
        warm_voltage_derate_q    <= 3'h0;
        thermal_current_derate_q <= 3'h0;
      end
    end
  end
endmodule // sctr_regbank
`default_nettype wire

// file: rtl/sctr_sync.v
// three-flop synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sctr_sync #(
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input  wire mclk,
  input  wire rstn,
  // signal
  input  wire din,
  output reg  dout_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // start at the pin's idle level so no false edge follows reset
      s1_q   <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
      dout_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts only when stages two and three agree
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end
endmodule // sctr_sync
`default_nettype wire

// file: testbench/sctr_host_model.sv
// host model: register accesses and serial transaction marks
`timescale 1ns/100ps
`default_nettype none
module sctr_host_model (
  // clock
  input  wire logic       mclk,
  // register access
  output var  logic       reg_wr = 1'b0,
  output var  logic       reg_rd = 1'b0,
  output var  logic [7:0] reg_addr = 8'h00,
  output var  logic [7:0] reg_wdata = 8'h00,
  output var  logic       bus_txn_done = 1'b0
);
  logic [7:0] exp_q[$];
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    if (!w) exp_q.push_back(d);
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released bus never keeps its last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic txn();
    @(posedge mclk);
    #1;
    bus_txn_done = 1'b1;
    @(posedge mclk);
    #1;
    bus_txn_done = 1'b0;
  endtask
endmodule // sctr_host_model
`default_nettype wire

// file: testbench/sctr_regbank_monitor.sv
// port-level assertions for the system control register bank
`timescale 1ns/100ps
`default_nettype none
module sctr_regbank_monitor #(
  parameter [4:0] HWRST_CYCLES = 5'h10
) (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // register access
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       bus_txn_done,
  // pins
  input wire logic       input_supply_good,
  input wire logic       charge_en_pin_n,
  input wire logic       power_good_pin_n_o,
  input wire logic       power_good_pin_n_oe,
  // control outputs
  input wire logic [2:0] sys_rail_target_sel_q,
  input wire logic       charge_allowed_q,
  input wire logic [2:0] zone_q,
  input wire logic [2:0] warm_voltage_derate_q,
  input wire logic [2:0] thermal_current_derate_q,
  input wire logic       hw_reset_q
);
  localparam int HWR_LAST = HWRST_CYCLES - 1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire mapped = reg_addr == 8'h36 || reg_addr == 8'h37 || (reg_addr >= 8'h61 && reg_addr <= 8'h65);
  // a forced default can land right after a write, so skip those
  property p_rail_wr;
    reg_wr && reg_addr == 8'h37 && !hw_reset_q ##1 !hw_reset_q |=> sys_rail_target_sel_q == $past(reg_wdata[7:5], 2);
  endproperty
  a_rail_wr: assert property (p_rail_wr) else $error("rail code not from write");
  a_rd_rsv: assert property (reg_rd && reg_addr == 8'h37 |=> reg_rdata_q[3:2] == 2'b00) else $error("reserved bits read back");
  a_rd_hole: assert property (reg_rd && !mapped |=> reg_rdata_q == 8'h00) else $error("hole reads nonzero");
  a_hw_len: assert property ($rose(hw_reset_q) |-> ##HWR_LAST hw_reset_q ##1 !hw_reset_q) else $error("reset pulse length");
  a_hw_dflt: assert property ($rose(hw_reset_q) |-> ##3 sys_rail_target_sel_q == 3'h2) else $error("rail not default");
  a_hw_cause: assert property ($rose(hw_reset_q) |-> input_supply_good && !$past(bus_txn_done)) else $error("reset w/o cause");
  a_od: assert property (power_good_pin_n_o == 1'b0) else $error("open drain drives high");
  // shadow of pin mode and output state bit, back to defaults on any reset
  logic [1:0] mode_sh;
  logic       gpo_sh;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_sh <= 2'h0;
      gpo_sh  <= 1'b0;
    end else if (hw_reset_q) begin
      mode_sh <= 2'h0;
      gpo_sh  <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h36) begin
      mode_sh <= reg_wdata[3:2];
    end else if (reg_wr && reg_addr == 8'h37) begin
      gpo_sh <= reg_wdata[4];
    end
  end
  property p_gpo;
    mode_sh[1] |=> power_good_pin_n_oe == !$past(gpo_sh);
  endproperty
  a_gpo: assert property (p_gpo) else $error("pin not following output bit");
  a_chg_pin: assert property (charge_en_pin_n [*8] |=> !charge_allowed_q) else $error("charge with pin high");
  a_derate: assert property (zone_q != 3'h3 && $past(zone_q) != 3'h3 && $past(zone_q, 2) != 3'h3
    |-> warm_voltage_derate_q == 3'h0 && thermal_current_derate_q == 3'h0) else $error("derate out of warm");
endmodule // sctr_regbank_monitor
bind sctr_regbank sctr_regbank_monitor #(.HWRST_CYCLES(HWRST_CYCLES)) u_mon (.mclk, .rstn, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata_q, .bus_txn_done, .input_supply_good, .charge_en_pin_n, .power_good_pin_n_o,
  .power_good_pin_n_oe,
  .sys_rail_target_sel_q, .charge_allowed_q, .zone_q, .warm_voltage_derate_q, .thermal_current_derate_q, .hw_reset_q);
`default_nettype wire

// file: testbench/sctr_regbank_tb.sv
// self-checking bench for the system control register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module sctr_regbank_tb;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic       input_supply_good = 1'b0;
  logic       charge_en_pin_n = 1'b1;
  logic       input_power_good = 1'b0;
  logic       button_level_n = 1'b1;
  logic [7:0] thermistor_sense = 8'h50;
  wire        reg_wr, reg_rd, bus_txn_done, pin_o, pin_oe, chg, hwr;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata_q;
  wire  [2:0] rail, zone, vder, ider;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         seed = 32'h9c2d;
  int         i;
  logic       rd_seen = 1'b0;
  logic [7:0] d;
  logic [7:0] zs[5] = '{8'h7C, 8'h6D, 8'h50, 8'h38, 8'h27};
  logic [2:0] zz[5] = '{3'h1, 3'h2, 3'h0, 3'h3, 3'h4};
  always #4 mclk = ~mclk;
  sctr_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .bus_txn_done(bus_txn_done));
  // short watchdog count keeps the run brief
  sctr_regbank #(.WD_CYCLES(32'd200), .HWRST_CYCLES(5'd16)) dut (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .bus_txn_done(bus_txn_done), .input_supply_good(input_supply_good), .charge_en_pin_n(charge_en_pin_n),
    .input_power_good(input_power_good), .button_level_n(button_level_n), .thermistor_sense(thermistor_sense),
    .power_good_pin_n_o(pin_o), .power_good_pin_n_oe(pin_oe), .sys_rail_target_sel_q(rail),
    .charge_allowed_q(chg), .zone_q(zone), .warm_voltage_derate_q(vder),
    .thermal_current_derate_q(ider), .hw_reset_q(hwr));
  always @(posedge mclk) rd_seen <= reg_rd;
  always @(posedge mclk) begin
    #1;
    if (rd_seen) `CHK(reg_rdata_q, host.exp_q.pop_front())
  end
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  initial begin
    #(20000 * 8);
    error_cnt++;
    give_verdict();
  end
  initial begin
    input_power_good = $random(seed);
    button_level_n = $random(seed);
    cyc(20);
    rstn = 1'b1;
    host.acc(0, 8'h37, 8'h40);
    host.acc(0, 8'h61, 8'h34);
    host.acc(0, 8'h62, 8'h7C);
    host.acc(0, 8'h63, 8'h6D);
    host.acc(0, 8'h64, 8'h38);
    host.acc(0, 8'h65, 8'h27);
    host.acc(0, 8'h36, 8'h00);
    host.acc(0, 8'h60, 8'h00);
    // zone ladder on the exact default limits
    for (i = 0; i < 5; i++) begin
      thermistor_sense = zs[i];
      cyc(4);
      `CHK(zone, zz[i])
      `CHK(vder, (zz[i] == 3'h3) ? 3'h3 : 3'h0)
      `CHK(ider, (zz[i] == 3'h3) ? 3'h4 : 3'h0)
    end
    d = $random(seed);
    host.acc(1, 8'h61, d);
    thermistor_sense = 8'h38;
    cyc(4);
    `CHK(vder, d[6:4])
    `CHK(ider, d[2:0])
    for (i = 0; i < 5; i++) begin
      d = $random(seed);
      host.acc(1, 8'h61 + i[7:0], d);
      host.acc(0, 8'h61 + i[7:0], d);
    end
    for (i = 0; i < 8; i++) begin
      host.acc(1, 8'h37, {i[2:0], 5'h1F});
      host.acc(0, 8'h37, {i[2:0], 5'h13});
      `CHK(rail, i[2:0])
    end
    // pin modes 00 and 01 follow the synchronised inputs
    for (i = 0; i < 4; i++) begin
      host.acc(1, 8'h36, {5'h00, i[0], 2'h0});
      input_power_good = $random(seed);
      button_level_n = $random(seed);
      cyc(8);
      `CHK(pin_oe, i[0] ? ~button_level_n : input_power_good)
    end
    // pin as general output; charge gate from bit and pin
    host.acc(1, 8'h36, 8'h08);
    charge_en_pin_n = 1'b0;
    for (i = 0; i < 4; i++) begin
      host.acc(1, 8'h37, {3'h2, i[0], 3'h0, i[1]});
      cyc(8);
      `CHK(pin_oe, ~i[0])
      `CHK(pin_o, 1'b0)
      `CHK(chg, ~i[1])
    end
    charge_en_pin_n = 1'b1;
    cyc(8);
    `CHK(chg, 1'b0)
    // unserviced watchdog fires, then a transaction keeps it quiet
    host.acc(1, 8'h37, 8'hE2);
    input_supply_good = 1'b1;
    for (i = 0; i < 400 && hwr !== 1'b1; i++) cyc(1);
    `CHK(i >= 198 && i <= 215, 1'b1)
    cyc(20);
    host.acc(0, 8'h37, 8'h40);
    host.acc(0, 8'h61, 8'h34);
    host.acc(0, 8'h65, 8'h27);
    host.acc(0, 8'h36, 8'h00);
    input_supply_good = 1'b0;
    host.acc(1, 8'h37, 8'h02);
    cyc(8);
    input_supply_good = 1'b1;
    cyc(50);
    host.txn();
    for (i = 0; i < 400 && hwr !== 1'b1; i++) cyc(1);
    `CHK(hwr, 1'b0)
    give_verdict();
  end
endmodule // sctr_regbank_tb
`default_nettype wire
